// ### hdl/pat_master.sv
// Purpose: protection master, per-stage alarm/trip timing, collectives and trip commands
// Assumes: all inputs synchronous to clk; registers over APB
// Notes: every output comes from a flip-flop
//
// Notes on behaviour
// RULE_01 - master trip-block permitted and its input true suppresses every trip command
// RULE_02 - a stage detecting its fault criterion asserts its own alarm
// RULE_03 - general alarm is the OR of all reporting stage alarms
// RULE_04 - stage trip only when fault persists past the full stage delay
// RULE_05 - general trip is the OR of all reporting stage trips
// RULE_06 - stage trip command needs trip and no block; absent when supervision-only
// RULE_07 - per-phase collective alarm ORs stage alarms of that phase
// RULE_08 - per-phase collective trip ORs stage trips of that phase
// RULE_09 - only single-phase capable, non-supervision stages feed phase collectives
// RULE_10 - ground stage alarms also feed a separate ground collective alarm
// RULE_11 - supervision-only stage feeds no collective and never commands the breaker
// RULE_12 - master function inactive disables all alarms, trips and commands
// RULE_13 - each module has an enable; while off, the module stays off
// RULE_14 - stage permanent inhibit never lets its trip command out
// RULE_15 - master external block permitted blocks all protection while input active
// RULE_16 - module blocked only while either block input active and permitted
// RULE_17 - stage trip-block permitted suppresses its command while input active
// RULE_18 - the trip manager opens only the breakers assigned to a command
// RULE_19 - fault lost before delay clears alarm and restarts timer next time
// RULE_20 - blocked or disabled modules drive nothing and feed no collective
`timescale 1ns/1ps
`include "pat_regs.svh"

module pat_master (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire pat_pkg::pat_addr_t paddr,
	input wire pat_pkg::pat_word_t pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output pat_pkg::pat_word_t prdata,
	output logic pslverr,
	// master blocking inputs
	input wire logic ext_block_input_one,
	input wire logic ext_block_input_two,
	input wire logic trip_block_input,
	// per-stage fault criteria and blocking inputs
	input wire pat_pkg::pat_stages_t stage_fault_l1,
	input wire pat_pkg::pat_stages_t stage_fault_l2,
	input wire pat_pkg::pat_stages_t stage_fault_l3,
	input wire pat_pkg::pat_stages_t stage_ext_block_input_one,
	input wire pat_pkg::pat_stages_t stage_ext_block_input_two,
	input wire pat_pkg::pat_stages_t stage_trip_block_input,
	// per-stage outputs
	output pat_pkg::pat_stages_t stage_alarm,
	output pat_pkg::pat_stages_t stage_trip,
	output pat_pkg::pat_stages_t trip_command_out,
	// master collectives
	output logic general_alarm,
	output logic general_trip,
	output logic alarm_l1,
	output logic alarm_l2,
	output logic alarm_l3,
	output logic trip_l1,
	output logic trip_l2,
	output logic trip_l3,
	output logic alarm_ground
);
	import pat_pkg::*;

	logic [`PAT_MST_W-1:0] master_reg;
	pat_word_t stage_cfg_reg [`PAT_NST];
	pat_delay_t cnt_reg [`PAT_NST];
	pat_delay_t cnt_next [`PAT_NST];
	logic pready_reg;

	pat_stages_t alarm_next;
	pat_stages_t trip_next;
	pat_stages_t cmd_next;
	logic [2:0] phase_alarm_next;
	logic [2:0] phase_trip_next;
	logic gen_alarm_next;
	logic gen_trip_next;
	logic ground_next;
	pat_word_t rdata_next;
	logic err_next;

	// index of a stage configuration word, or -1 if not a stage address
	function automatic int stage_index(input pat_addr_t a);
		int k;
		stage_index = -1;
		for (k = 0; k < `PAT_NST; k++) begin
			if (a == `PAT_AW'(`PAT_ADDR_STAGE_BASE + 4 * k)) begin
				stage_index = k;
			end
		end
	endfunction : stage_index

	// delay field of a stage configuration word
	function automatic pat_delay_t cfg_delay(input pat_word_t w);
		cfg_delay = w[`PAT_CFG_DLY_HI:`PAT_CFG_DLY_LO];
	endfunction : cfg_delay

	// byte-lane merge of a write into a stored word
	function automatic pat_word_t lane_merge(input pat_word_t old, input pat_word_t nw,
			input logic [3:0] strb);
		int b;
		lane_merge = old;
		for (b = 0; b < 4; b++) begin
			if (strb[b]) begin
				lane_merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction : lane_merge

	// stage logic and collectives
	always_comb begin
		logic master_on;
		logic master_cmd_ok;
		logic active;
		logic fault;
		logic elapsed;
		logic reports;
		logic phased;
		logic cmd_ok;
		pat_word_t c;
		master_on = 1'b0;
		master_cmd_ok = 1'b0;
		active = 1'b0;
		fault = 1'b0;
		elapsed = 1'b0;
		reports = 1'b0;
		phased = 1'b0;
		cmd_ok = 1'b0;
		c = `PAT_ZERO_WORD;
		alarm_next = '0;
		trip_next = '0;
		cmd_next = '0;
		phase_alarm_next = '0;
		phase_trip_next = '0;
		gen_alarm_next = 1'b0;
		gen_trip_next = 1'b0;
		ground_next = 1'b0;
		master_on = master_reg[`PAT_MST_FUNC] // see RULE_12
			& ~(master_reg[`PAT_MST_EXT_PERMIT]
			& (ext_block_input_one | ext_block_input_two)); // see RULE_15
		master_cmd_ok = ~master_reg[`PAT_MST_INHIBIT]
			& ~(master_reg[`PAT_MST_TRIP_PERMIT] & trip_block_input); // see RULE_01
		for (int i = 0; i < `PAT_NST; i++) begin
			c = stage_cfg_reg[i];
			cnt_next[i] = `PAT_ZERO_DLY;
			active = master_on & c[`PAT_CFG_ENABLE] // see RULE_13
				& ~(c[`PAT_CFG_EXT_PERMIT] & (stage_ext_block_input_one[i]
				| stage_ext_block_input_two[i])); // see RULE_16
			fault = active & (stage_fault_l1[i] | stage_fault_l2[i] | stage_fault_l3[i]);
			elapsed = cnt_reg[i] >= cfg_delay(c);
			if (fault && !elapsed) begin
				cnt_next[i] = cnt_reg[i] + `PAT_ONE_DLY;
			end else if (fault) begin
				cnt_next[i] = cnt_reg[i];
			end // else timer restarts from zero, see RULE_19
			alarm_next[i] = fault; // see RULE_02, RULE_19, RULE_20
			trip_next[i] = fault & elapsed; // see RULE_04
			cmd_ok = ~c[`PAT_CFG_SUPERV] & ~c[`PAT_CFG_INHIBIT] // see RULE_11, RULE_14
				& ~(c[`PAT_CFG_TRIP_PERMIT] & stage_trip_block_input[i]); // see RULE_17
			cmd_next[i] = trip_next[i] & cmd_ok & master_cmd_ok; // see RULE_06, RULE_01
			reports = ~c[`PAT_CFG_SUPERV]; // see RULE_11
			phased = reports & c[`PAT_CFG_PHASE]; // see RULE_09
			gen_alarm_next = gen_alarm_next | (reports & alarm_next[i]); // see RULE_03
			gen_trip_next = gen_trip_next | (reports & trip_next[i]); // see RULE_05
			ground_next = ground_next
				| (reports & c[`PAT_CFG_GROUND] & alarm_next[i]); // see RULE_10
			if (phased) begin
				phase_alarm_next = phase_alarm_next | ({stage_fault_l3[i],
					stage_fault_l2[i], stage_fault_l1[i]} & {3{alarm_next[i]}}); // see RULE_07
				phase_trip_next = phase_trip_next | ({stage_fault_l3[i],
					stage_fault_l2[i], stage_fault_l1[i]} & {3{trip_next[i]}}); // see RULE_08
			end
		end
	end

	// timers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `PAT_NST; i++) begin
				cnt_reg[i] <= `PAT_ZERO_DLY;
			end
		end else begin
			for (int i = 0; i < `PAT_NST; i++) begin
				cnt_reg[i] <= cnt_next[i];
			end
		end
	end

	// stage and collective outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stage_alarm <= '0;
			stage_trip <= '0;
			trip_command_out <= '0;
			general_alarm <= 1'b0;
			general_trip <= 1'b0;
			alarm_l1 <= 1'b0;
			alarm_l2 <= 1'b0;
			alarm_l3 <= 1'b0;
			trip_l1 <= 1'b0;
			trip_l2 <= 1'b0;
			trip_l3 <= 1'b0;
			alarm_ground <= 1'b0;
		end else begin
			stage_alarm <= alarm_next;
			stage_trip <= trip_next;
			trip_command_out <= cmd_next;
			general_alarm <= gen_alarm_next;
			general_trip <= gen_trip_next;
			alarm_l1 <= phase_alarm_next[0];
			alarm_l2 <= phase_alarm_next[1];
			alarm_l3 <= phase_alarm_next[2];
			trip_l1 <= phase_trip_next[0];
			trip_l2 <= phase_trip_next[1];
			trip_l3 <= phase_trip_next[2];
			alarm_ground <= ground_next;
		end
	end

	// read mux and error decode
	always_comb begin
		int k;
		k = stage_index(paddr);
		rdata_next = `PAT_ZERO_WORD;
		err_next = 1'b0;
		if (paddr == `PAT_ADDR_MASTER) begin
			rdata_next[`PAT_MST_W-1:0] = master_reg;
		end else if (paddr == `PAT_ADDR_STATUS) begin
			rdata_next[`PAT_ST_ALARM] = general_alarm;
			rdata_next[`PAT_ST_TRIP] = general_trip;
			rdata_next[`PAT_ST_AL1] = alarm_l1;
			rdata_next[`PAT_ST_AL2] = alarm_l2;
			rdata_next[`PAT_ST_AL3] = alarm_l3;
			rdata_next[`PAT_ST_TL1] = trip_l1;
			rdata_next[`PAT_ST_TL2] = trip_l2;
			rdata_next[`PAT_ST_TL3] = trip_l3;
			rdata_next[`PAT_ST_AG] = alarm_ground;
		end else if (paddr == `PAT_ADDR_STAGE_STATE) begin
			rdata_next[`PAT_NST-1:0] = stage_alarm;
			rdata_next[`PAT_SS_TRIP_LO +: `PAT_NST] = stage_trip;
			rdata_next[`PAT_SS_CMD_LO +: `PAT_NST] = trip_command_out;
		end else if (k >= 0) begin
			rdata_next = stage_cfg_reg[k];
		end else begin
			err_next = 1'b1;
		end
	end

	// apb handshake: one access cycle, answer registered at setup
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_reg <= 1'b0;
			prdata <= `PAT_ZERO_WORD;
			pslverr <= 1'b0;
		end else begin
			pready_reg <= psel & ~penable & ~pready_reg;
			if (psel && !penable) begin
				prdata <= pwrite ? `PAT_ZERO_WORD : rdata_next;
				pslverr <= err_next;
			end else if (pready_reg) begin
				prdata <= `PAT_ZERO_WORD;
				pslverr <= 1'b0;
			end
		end
	end

	assign pready = pready_reg;

	// master settings write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			master_reg <= `PAT_MST_RESET;
		end else if (psel && penable && pready_reg && pwrite && pstrb[0]
				&& paddr == `PAT_ADDR_MASTER) begin
			master_reg <= pwdata[`PAT_MST_W-1:0];
		end
	end

	// stage settings write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `PAT_NST; i++) begin
				stage_cfg_reg[i] <= `PAT_CFG_RESET;
			end
		end else if (psel && penable && pready_reg && pwrite) begin
			for (int i = 0; i < `PAT_NST; i++) begin
				if (stage_index(paddr) == i) begin
					stage_cfg_reg[i] <= lane_merge(stage_cfg_reg[i], pwdata, pstrb);
				end
			end
		end
	end

endmodule : pat_master

// ### hdl/pat_pkg.sv
// Purpose: shared types of the protection master
// Assumes: constants come from pat_regs.svh
// Notes: types only
`include "pat_regs.svh"
package pat_pkg;
	typedef logic [31:0] pat_word_t;
	typedef logic [`PAT_AW-1:0] pat_addr_t;
	typedef logic [15:0] pat_delay_t;
	typedef logic [`PAT_NST-1:0] pat_stages_t;
endpackage : pat_pkg

// ### hdl/pat_regs.svh
// Purpose: register map, field positions and reset values of the protection master
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: stage configuration words sit at consecutive words from the stage base
`ifndef PAT_REGS_SVH
`define PAT_REGS_SVH

`define PAT_NST 4
`define PAT_AW 8

`define PAT_ADDR_MASTER 8'h00
`define PAT_ADDR_STATUS 8'h04
`define PAT_ADDR_STAGE_STATE 8'h08
`define PAT_ADDR_STAGE_BASE 8'h10

`define PAT_MST_FUNC 0
`define PAT_MST_EXT_PERMIT 1
`define PAT_MST_TRIP_PERMIT 2
`define PAT_MST_INHIBIT 3
`define PAT_MST_W 4
`define PAT_MST_RESET 4'h1

`define PAT_CFG_ENABLE 0
`define PAT_CFG_EXT_PERMIT 1
`define PAT_CFG_TRIP_PERMIT 2
`define PAT_CFG_INHIBIT 3
`define PAT_CFG_SUPERV 4
`define PAT_CFG_PHASE 5
`define PAT_CFG_GROUND 6
`define PAT_CFG_DLY_LO 16
`define PAT_CFG_DLY_HI 31
`define PAT_CFG_RESET 32'h0000_0000

`define PAT_ST_ALARM 0
`define PAT_ST_TRIP 1
`define PAT_ST_AL1 2
`define PAT_ST_AL2 3
`define PAT_ST_AL3 4
`define PAT_ST_TL1 5
`define PAT_ST_TL2 6
`define PAT_ST_TL3 7
`define PAT_ST_AG 8

`define PAT_SS_TRIP_LO 8
`define PAT_SS_CMD_LO 16

`define PAT_ZERO_WORD 32'h0000_0000
`define PAT_ZERO_DLY 16'h0000
`define PAT_ONE_DLY 16'h0001

`endif

// ### testbench/pat_master_sva.sv
// Purpose: concurrent checks on the protection master ports
// Assumes: all signals in the clk domain, arst_n active low
// Notes: bound into every pat_master instance
`timescale 1ns/1ps
module pat_master_sva (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// stage side
	input wire pat_pkg::pat_stages_t stage_fault_l1,
	input wire pat_pkg::pat_stages_t stage_fault_l2,
	input wire pat_pkg::pat_stages_t stage_fault_l3,
	input wire pat_pkg::pat_stages_t stage_alarm,
	input wire pat_pkg::pat_stages_t stage_trip,
	input wire pat_pkg::pat_stages_t trip_command_out,
	// collectives
	input wire logic general_alarm,
	input wire logic general_trip,
	input wire logic alarm_l1,
	input wire logic trip_l1,
	input wire logic alarm_ground
);
	import pat_pkg::*;
	pat_stages_t flt;
	assign flt = stage_fault_l1 | stage_fault_l2 | stage_fault_l3;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_alarm_cause: assert property ((stage_alarm & ~$past(flt)) == '0)
		else $error("stage alarm without fault");
	chk_gen_alarm: assert property (general_alarm |-> |stage_alarm)
		else $error("general alarm without stage alarm");
	chk_gen_trip: assert property (general_trip |-> |stage_trip)
		else $error("general trip without stage trip");
	chk_trip_alarm: assert property ((stage_trip & ~stage_alarm) == '0)
		else $error("trip without alarm");
	chk_cmd_trip: assert property ((trip_command_out & ~stage_trip) == '0)
		else $error("command without trip");
	chk_phase_alarm: assert property (alarm_l1 |-> general_alarm && $past(|stage_fault_l1))
		else $error("phase alarm without cause");
	chk_phase_trip: assert property (trip_l1 |-> general_trip && $past(|stage_fault_l1))
		else $error("phase trip without cause");
	chk_ground_alarm: assert property (alarm_ground |-> general_alarm)
		else $error("ground alarm alone");
	chk_fault_gone: assert property (stage_alarm[0] && !flt[0] |=> !stage_alarm[0] && !stage_trip[0])
		else $error("alarm kept after fault loss");
	cover property (trip_command_out[0]);
	cover property (stage_trip[0] && !general_trip);
	cover property (stage_trip[0] && !trip_command_out[0]);
endmodule : pat_master_sva
bind pat_master pat_master_sva chk_u (.clk, .arst_n, .stage_fault_l1, .stage_fault_l2,
	.stage_fault_l3, .stage_alarm, .stage_trip, .trip_command_out, .general_alarm,
	.general_trip, .alarm_l1, .trip_l1, .alarm_ground);

// ### testbench/pat_master_tb.sv
// Purpose: self-checking bench of the protection master
// Assumes: stage 0 faults on phase l1 with a delay of two clocks
// Notes: breaker a takes stage 0 commands, breaker b stage 1
`timescale 1ns/1ps
`include "pat_regs.svh"
module protection_alarm_trip_blocking_tb_top;
	import pat_pkg::*;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, er, general_alarm, general_trip, alarm_l1, alarm_ground, brk_a, brk_b;
	pat_addr_t paddr = '0;
	pat_word_t pwdata = '0, prdata, rd;
	pat_stages_t f1 = '0, stage_alarm, stage_trip, trip_command_out;
	logic [5:0] blk = '0;
	logic [8:0] obs;
	int err_total = 0, compares = 0;
	assign obs = {trip_command_out[0], stage_trip[0], stage_alarm[0], general_alarm,
		general_trip, alarm_l1, alarm_ground, brk_a, brk_b};
	always #2 clk = ~clk;
	pat_master dut_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
		.pready, .prdata, .pslverr, .ext_block_input_one(blk[5]), .ext_block_input_two(blk[4]),
		.trip_block_input(blk[3]), .stage_fault_l1(f1), .stage_fault_l2(4'h0),
		.stage_fault_l3(4'h0), .stage_ext_block_input_one({3'h0, blk[2]}),
		.stage_ext_block_input_two({3'h0, blk[1]}), .stage_trip_block_input({3'h0, blk[0]}),
		.stage_alarm, .stage_trip, .trip_command_out, .general_alarm, .general_trip, .alarm_l1,
		.alarm_l2(), .alarm_l3(), .trip_l1(), .trip_l2(), .trip_l3(), .alarm_ground);
	pat_trip_mgr #(.ASSIGN(4'h1)) brk_a_u (.clk, .arst_n, .trip_command_out, .breaker_open(brk_a));
	pat_trip_mgr #(.ASSIGN(4'h2)) brk_b_u (.clk, .arst_n, .trip_command_out, .breaker_open(brk_b));
	task automatic chk(input pat_word_t got, input pat_word_t exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic wr, input pat_addr_t a, input pat_word_t d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic scen(input pat_word_t m, input pat_word_t s, input logic [5:0] b,
		input logic [8:0] e);
		apb(1'b1, `PAT_ADDR_MASTER, m);
		apb(1'b1, `PAT_ADDR_STAGE_BASE, s);
		blk <= b;
		f1 <= 4'h1;
		repeat (2) @(posedge clk);
		#1;
		chk(stage_trip[0], 0);
		repeat (3) @(posedge clk);
		#1;
		chk(obs, e);
		apb(1'b0, `PAT_ADDR_STAGE_STATE, 0);
		chk(rd, {15'h0000, e[8], 7'h00, e[7], 7'h00, e[6]});
		f1 <= 4'h0;
		blk <= 6'h00;
		repeat (2) @(posedge clk);
		#1;
		chk(obs, 0);
	endtask : scen
	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		apb(1'b0, `PAT_ADDR_MASTER, 0);
		chk(rd, `PAT_MST_RESET);
		apb(1'b0, `PAT_ADDR_STAGE_BASE, 0);
		chk(rd, `PAT_CFG_RESET);
		apb(1'b0, 8'hfc, 0);
		chk(er, 1);
		scen(1, 32'h0002_0061, 6'h00, 9'h1fe);
		scen(1, 32'h0002_0065, 6'h01, 9'h0fc);
		scen(1, 32'h0002_0061, 6'h01, 9'h1fe);
		scen(5, 32'h0002_0061, 6'h08, 9'h0fc);
		scen(1, 32'h0002_0061, 6'h08, 9'h1fe);
		scen(1, 32'h0002_0069, 6'h00, 9'h0fc);
		scen(1, 32'h0002_0071, 6'h00, 9'h0c0);
		scen(3, 32'h0002_0061, 6'h20, 9'h000);
		scen(3, 32'h0002_0061, 6'h10, 9'h000);
		scen(1, 32'h0002_0061, 6'h20, 9'h1fe);
		scen(0, 32'h0002_0061, 6'h00, 9'h000);
		scen(1, 32'h0002_0060, 6'h00, 9'h000);
		scen(1, 32'h0002_0063, 6'h04, 9'h000);
		scen(1, 32'h0002_0063, 6'h02, 9'h000);
		scen(1, 32'h0002_0041, 6'h00, 9'h1f6);
		scen(1, 32'h0002_0021, 6'h00, 9'h1fa);
		scen(1, 32'h0002_0061, 6'h04, 9'h1fe);
		@(posedge clk);
		f1 <= 4'h1;
		repeat (2) @(posedge clk);
		f1 <= 4'h0;
		@(posedge clk);
		f1 <= 4'h1;
		repeat (2) @(posedge clk);
		#1;
		chk(stage_trip[0], 0);
		chk(stage_alarm[0], 1);
		report_and_stop();
	end
endmodule : protection_alarm_trip_blocking_tb_top

// ### testbench/pat_trip_mgr.sv
// Purpose: trip manager model driving one breaker
// Assumes: trip commands are registered levels
// Notes: breaker opens one clock after an assigned command
`timescale 1ns/1ps
module pat_trip_mgr #(
	parameter pat_pkg::pat_stages_t ASSIGN = 4'h1
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// commands and breaker
	input wire pat_pkg::pat_stages_t trip_command_out,
	output logic breaker_open
);
	import pat_pkg::*;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) breaker_open <= 1'b0;
		else breaker_open <= |(trip_command_out & ASSIGN);
	end
endmodule : pat_trip_mgr
